// ---- inc/msc_pkg.sv ----
// Shared constants and state types of the module sideband control block
package msc_pkg;
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          INIT_TIME_MS    = 2000;
    localparam int          INIT_CYCLES     = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam int          RST_FILT_CYCLES = 16;
    localparam int          LANES           = 4;
    localparam int          MON_W           = 16;
    localparam logic [6:0]  DEV_ADDR        = 7'h50;
    localparam logic [15:0] LOS_THR_RST     = 16'h0010;
    localparam logic        TXDIS_RST       = 1'b0;
    localparam logic [7:0]  ADR_STATUS      = 8'h00;
    localparam logic [7:0]  ADR_LANE_LOS    = 8'h01;
    localparam logic [7:0]  ADR_CONTROL     = 8'h02;
    localparam logic [7:0]  ADR_FLAGS       = 8'h03;
    localparam logic [7:0]  ADR_MON_BASE    = 8'h04;
    localparam logic [7:0]  ADR_THR_HI      = 8'h0C;
    localparam logic [7:0]  ADR_THR_LO      = 8'h0D;
    localparam int          ST_INIT_BIT     = 0;
    localparam int          ST_LOS_BIT      = 1;
    localparam int          ST_LPM_BIT      = 2;
    localparam int          CTL_TXDIS_BIT   = 0;
    localparam int          FLG_INIT_BIT    = 0;
    localparam int          FLG_LOS_BIT     = 1;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'b001,
        ST_INIT  = 3'b010,
        ST_READY = 3'b100
    } msc_state_t;

    typedef enum logic [3:0] {
        SL_IDLE  = 4'b0001,
        SL_ADDR  = 4'b0010,
        SL_WRITE = 4'b0100,
        SL_READ  = 4'b1000
    } msc_slave_t;
endpackage

// ---- logic/msc_sideband.sv ----
// Sideband control: reset, init, interrupt, tx disable, alarms, monitors
// Function
// - Eight pins: select, bus clock, bus data, reset, low power, tx disable, present, irq
// - Bus commands are answered only while select is held low
// - Bus clock and data give read and write access to the map
// - Reset held past minimum length restores every setting to default
// - Completion clears the init pending bit and asserts the interrupt
// - Power-up raises the completion interrupt without any reset pulse
// - Power-on initialisation completes within 2000 ms
// - Low power select input caps maximum power consumption
// - Present output pulls the host presence line low when inserted
// - Interrupt pin driven low while the init or loss event flag is set, else released
// - Transmitter off when pin disable or register disable is set
// - Loss alarm when any lane's received power falls below threshold
// - Each lane's received power monitor is readable over the bus
`timescale 1ns/1ps
module msc_sideband #(
    parameter int          INIT_CYC = msc_pkg::INIT_CYCLES,     // Init time
    parameter int          RST_FILT = msc_pkg::RST_FILT_CYCLES, // Filter
    parameter logic [15:0] THR_RST  = msc_pkg::LOS_THR_RST,     // LOS level
    parameter logic [6:0]  DEV_ADDR = msc_pkg::DEV_ADDR         // Bus address
) (
    input  logic        clk_sys,           // System clock
    input  logic        rst_b,             // Power-up reset
    input  logic        clk_link,          // Link clock
    input  logic        moduleSelectN,     // Select pin
    input  logic        moduleResetN,      // Reset pin
    input  logic        lowPowerSelect,    // Low power pin
    input  logic        transmitDisable,   // Tx disable pin
    input  logic        sclIn,             // Bus clock pin
    input  logic        sdaIn,             // Bus data pin level
    output logic        sdaOut,            // Bus data drive value
    output logic        sdaOe,             // Bus data enable
    input  logic [63:0] diagnosticMonitor, // Lane power words
    output logic        modulePresentN,    // Presence pin
    output logic        interruptNOut,     // Interrupt drive value
    output logic        interruptNOe,      // Interrupt enable
    output logic        txOff,             // Transmitter off
    output logic        lowPowerActive,    // Power cap active
    output logic        receiveLossAlarm,  // Loss of signal alarm
    output logic        initPending        // Init not finished
);
    import msc_pkg::*;

    localparam int ICW = $clog2(INIT_CYC + 1);
    localparam int FW  = $clog2(RST_FILT + 2);

    logic [1:0]       linkRst;
    logic [2:0]       pinSync1, pinSync2;
    logic             rstS, lpS, txDisS;
    logic             lnkTgl, lnkWe;
    logic [7:0]       lnkAddr, lnkData;
    logic [1:0]       reqSync;
    logic             reqPrev, reqSeen, ackTgl;
    logic [7:0]       rdData, rdMux, monOff;
    logic [MON_W-1:0] monWord;
    logic [FW-1:0]    filtCnt;
    logic             rstHeld;
    logic [ICW-1:0]   initCnt;
    logic             initDone;
    msc_state_t       state;
    logic             softTxDis;
    logic [15:0]      losThr;
    logic [LANES-1:0] laneLos, laneLosReg;
    logic [1:0]       flags, flagSet, flagClr;
    logic             wrEn;

    // Link-domain reset release
    always_ff @(posedge clk_link) begin
        linkRst <= {linkRst[0], rst_b};
    end

    msc_twowire_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_slave (
        .clk_link (clk_link),
        .rstLinkB (linkRst[1]),
        .sclPin   (sclIn),
        .sdaPin   (sdaIn),
        .selectN  (moduleSelectN),
        .sdaOut   (sdaOut),
        .sdaOe    (sdaOe),
        .reqTgl   (lnkTgl),
        .reqWe    (lnkWe),
        .reqAddr  (lnkAddr),
        .reqData  (lnkData),
        .ackTgl   (ackTgl),
        .rdData   (rdData)
    );

    // Pin synchronisers: reset, low power, tx disable
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pinSync1 <= 3'b101;
            pinSync2 <= 3'b101;
        end else begin
            pinSync1 <= {transmitDisable, lowPowerSelect, moduleResetN};
            pinSync2 <= pinSync1;
        end
    end

    assign rstS   = pinSync2[0];
    assign lpS    = pinSync2[1];
    assign txDisS = pinSync2[2];

    // Request toggle crossing from the link side
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reqSync <= 2'b00;
            reqPrev <= 1'b0;
        end else begin
            reqSync <= {reqSync[0], lnkTgl};
            reqPrev <= reqSync[1];
        end
    end

    assign reqSeen = reqSync[1] ^ reqPrev;
    assign wrEn    = reqSeen && lnkWe && state != ST_HOLD && !rstHeld;

    // Reset pulse filter
    always_ff @(posedge clk_sys) begin
        if (!rst_b || rstS) begin
            filtCnt <= '0;
        end else if (filtCnt != FW'(RST_FILT)) begin
            filtCnt <= filtCnt + FW'(1);
        end
    end

    assign rstHeld  = filtCnt == FW'(RST_FILT);
    assign initDone = state == ST_INIT && initCnt == ICW'(INIT_CYC - 1);

    // Reset and initialisation sequence
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state       <= ST_INIT;
            initCnt     <= '0;
            initPending <= 1'b1;
        end else if (rstHeld) begin
            state       <= ST_HOLD;
            initCnt     <= '0;
            initPending <= 1'b1;
        end else begin
            case (state)
                ST_HOLD: begin
                    state <= ST_INIT;
                end
                ST_INIT: begin
                    if (initDone) begin
                        state       <= ST_READY;
                        initPending <= 1'b0;
                    end else begin
                        initCnt <= initCnt + ICW'(1);
                    end
                end
                ST_READY: begin
                    state <= ST_READY;
                end
                default: begin
                    state <= ST_INIT;
                end
            endcase
        end
    end

    // Software settings
    always_ff @(posedge clk_sys) begin
        if (!rst_b || state == ST_HOLD) begin
            softTxDis <= TXDIS_RST;
            losThr    <= THR_RST;
        end else if (wrEn) begin
            if (lnkAddr == ADR_CONTROL) begin
                softTxDis <= lnkData[CTL_TXDIS_BIT];
            end else if (lnkAddr == ADR_THR_HI) begin
                losThr[15:8] <= lnkData;
            end else if (lnkAddr == ADR_THR_LO) begin
                losThr[7:0] <= lnkData;
            end
        end
    end

    // Per-lane loss of signal
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            laneLos[i] = diagnosticMonitor[i*MON_W +: MON_W] < losThr;
        end
    end

    // Sticky event flags, set wins over write-one clear
    always_comb begin
        flagSet = 2'b00;
        flagSet[FLG_INIT_BIT] = initDone && !rstHeld;
        flagSet[FLG_LOS_BIT]  = (|laneLos) && !receiveLossAlarm;
        flagClr = (wrEn && lnkAddr == ADR_FLAGS) ? lnkData[1:0] : 2'b00;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || state == ST_HOLD) begin
            flags <= 2'b00;
        end else begin
            flags <= (flags & ~flagClr) | flagSet;
        end
    end

    // Pin-facing outputs
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            modulePresentN   <= 1'b0;
            interruptNOut    <= 1'b0;
            interruptNOe     <= 1'b0;
            txOff            <= 1'b0;
            lowPowerActive   <= 1'b0;
            receiveLossAlarm <= 1'b0;
            laneLosReg       <= '0;
        end else begin
            modulePresentN   <= 1'b0;
            interruptNOut    <= 1'b0;
            interruptNOe     <= |flags;
            txOff            <= txDisS || softTxDis;
            lowPowerActive   <= lpS;
            receiveLossAlarm <= |laneLos;
            laneLosReg       <= laneLos;
        end
    end

    // Read data selection
    assign monOff  = lnkAddr - ADR_MON_BASE;
    assign monWord = diagnosticMonitor[monOff[2:1]*MON_W +: MON_W];

    always_comb begin
        rdMux = 8'h00;
        if (lnkAddr == ADR_STATUS) begin
            rdMux[ST_INIT_BIT] = initPending;
            rdMux[ST_LOS_BIT]  = receiveLossAlarm;
            rdMux[ST_LPM_BIT]  = lowPowerActive;
        end else if (lnkAddr == ADR_LANE_LOS) begin
            rdMux[LANES-1:0] = laneLosReg;
        end else if (lnkAddr == ADR_CONTROL) begin
            rdMux[CTL_TXDIS_BIT] = softTxDis;
        end else if (lnkAddr == ADR_FLAGS) begin
            rdMux[1:0] = flags;
        end else if (lnkAddr >= ADR_MON_BASE && lnkAddr < ADR_THR_HI) begin
            rdMux = monOff[0] ? monWord[7:0] : monWord[15:8];
        end else if (lnkAddr == ADR_THR_HI) begin
            rdMux = losThr[15:8];
        end else if (lnkAddr == ADR_THR_LO) begin
            rdMux = losThr[7:0];
        end
    end

    // Answer every request, reads carry data
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ackTgl <= 1'b0;
            rdData <= 8'h00;
        end else if (reqSeen) begin
            ackTgl <= ~ackTgl;
            if (!lnkWe) begin
                rdData <= rdMux;
            end
        end
    end

    // Helper: consecutive low cycles of the synced reset pin
    int lowRun;
    always_ff @(posedge clk_sys) begin
        if (!rst_b || rstS) begin
            lowRun <= 0;
        end else begin
            lowRun <= lowRun + 1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_present_low: assert property (
        ##1 !modulePresentN)
        else $error("presence pin not low");
    a_pwrup_init: assert property (
        $past(!rst_b) |-> state == ST_INIT && initPending)
        else $error("power-up did not start init");
    a_filter_len: assert property (
        $rose(state == ST_HOLD) |-> lowRun > RST_FILT)
        else $error("short reset pulse accepted");
    a_hold_default: assert property (
        state == ST_HOLD |=> softTxDis == TXDIS_RST && losThr == THR_RST)
        else $error("settings not defaulted on reset");
    a_init_irq: assert property (
        $fell(initPending) |-> flags[FLG_INIT_BIT] ##1 interruptNOe)
        else $error("completion not signalled");
    a_init_bound: assert property (
        state == ST_INIT |-> initCnt < ICW'(INIT_CYC))
        else $error("init exceeded its time");
    a_irq_drive: assert property (
        (|flags) |=> interruptNOe)
        else $error("interrupt not driven");
    a_soft_txdis: assert property (
        wrEn && lnkAddr == ADR_CONTROL && lnkData[CTL_TXDIS_BIT]
        |=> ##1 txOff)
        else $error("register disable ignored");
    a_los_alarm: assert property (
        (|laneLos) |=> receiveLossAlarm)
        else $error("loss alarm missing");
    a_ack_once: assert property (
        reqSeen |=> ackTgl != $past(ackTgl))
        else $error("request not answered");

    cv_init_done: cover property ($fell(initPending));
    cv_mod_reset: cover property ($rose(state == ST_HOLD));
    cv_bus_write: cover property (wrEn);
    cv_los_event: cover property (flagSet[FLG_LOS_BIT]);
endmodule

// ---- logic/msc_twowire_slave.sv ----
// Two-wire bus target on the link clock, word handshake to system side
`timescale 1ns/1ps
module msc_twowire_slave #(
    parameter logic [6:0] DEV_ADDR = msc_pkg::DEV_ADDR // Bus address
) (
    input  logic       clk_link,  // Oversampling link clock
    input  logic       rstLinkB,  // Link-domain reset, active low
    input  logic       sclPin,    // Bus clock pin
    input  logic       sdaPin,    // Bus data pin level
    input  logic       selectN,   // Module select pin
    output logic       sdaOut,    // Data pin drive value
    output logic       sdaOe,     // Data pin enable
    output logic       reqTgl,    // Request toggle
    output logic       reqWe,     // Request is a write
    output logic [7:0] reqAddr,   // Request address
    output logic [7:0] reqData,   // Request write data
    input  logic       ackTgl,    // Answer toggle
    input  logic [7:0] rdData     // Answer read data
);
    import msc_pkg::*;

    logic [1:0] sclSync, sdaSync, selSync, ackSync;
    logic       sclPrev, sdaPrev, ackPrev;
    logic       selected, startC, stopC, riseC, fallC;
    logic [7:0] shift, ptr, rdBuf;
    logic [3:0] cnt;
    logic       rw, first, mAck;
    msc_slave_t state;

    always_ff @(posedge clk_link) begin
        if (!rstLinkB) begin
            sclSync <= 2'b11;
            sdaSync <= 2'b11;
            selSync <= 2'b11;
            ackSync <= 2'b00;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
            ackPrev <= 1'b0;
        end else begin
            sclSync <= {sclSync[0], sclPin};
            sdaSync <= {sdaSync[0], sdaPin};
            selSync <= {selSync[0], selectN};
            ackSync <= {ackSync[0], ackTgl};
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
            ackPrev <= ackSync[1];
        end
    end

    assign selected = !selSync[1];
    assign startC = selected && sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
    assign stopC  = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];
    assign riseC  = sclSync[1] && !sclPrev;
    assign fallC  = !sclSync[1] && sclPrev;

    always_ff @(posedge clk_link) begin
        if (!rstLinkB) begin
            rdBuf <= 8'h00;
        end else if (ackSync[1] ^ ackPrev) begin
            rdBuf <= rdData;
        end
    end

    always_ff @(posedge clk_link) begin
        sdaOut <= 1'b0;
        if (!rstLinkB) begin
            state <= SL_IDLE; sdaOe <= 1'b0; cnt <= 4'h0;
            shift <= 8'h00; ptr <= 8'h00; rw <= 1'b0;
            first <= 1'b0; mAck <= 1'b0; reqTgl <= 1'b0;
            reqWe <= 1'b0; reqAddr <= 8'h00; reqData <= 8'h00;
        end else if (!selected) begin
            state <= SL_IDLE;
            sdaOe <= 1'b0;
        end else if (startC) begin
            state <= SL_ADDR; cnt <= 4'h0; sdaOe <= 1'b0;
        end else if (stopC) begin
            state <= SL_IDLE; sdaOe <= 1'b0;
        end else if (riseC && state != SL_IDLE) begin
            if (cnt < 4'h8 && state != SL_READ) begin
                shift <= {shift[6:0], sdaSync[1]};
            end
            if (cnt == 4'h8 && state == SL_READ) begin
                mAck <= !sdaSync[1];
            end
            cnt <= cnt + 4'h1;
        end else if (fallC && state != SL_IDLE) begin
            if (cnt == 4'h9) begin
                cnt <= 4'h0;
            end
            case (state)
                SL_ADDR: begin
                    if (cnt == 4'h8) begin
                        if (shift[7:1] == DEV_ADDR) begin
                            sdaOe <= 1'b1;
                            rw <= shift[0];
                            if (shift[0]) begin
                                reqWe <= 1'b0; reqAddr <= ptr;
                                reqTgl <= ~reqTgl;
                            end
                        end else begin
                            state <= SL_IDLE;
                        end
                    end else if (cnt == 4'h9) begin
                        if (rw) begin
                            state <= SL_READ; shift <= rdBuf;
                            sdaOe <= !rdBuf[7]; ptr <= ptr + 8'h01;
                            reqAddr <= ptr + 8'h01; reqTgl <= ~reqTgl;
                        end else begin
                            state <= SL_WRITE; sdaOe <= 1'b0; first <= 1'b1;
                        end
                    end
                end
                SL_WRITE: begin
                    if (cnt == 4'h8) begin
                        sdaOe <= 1'b1;
                        first <= 1'b0;
                        if (first) begin
                            ptr <= shift;
                        end else begin
                            reqWe <= 1'b1; reqAddr <= ptr; reqData <= shift;
                            reqTgl <= ~reqTgl; ptr <= ptr + 8'h01;
                        end
                    end else if (cnt == 4'h9) begin
                        sdaOe <= 1'b0;
                    end
                end
                SL_READ: begin
                    if (cnt >= 4'h1 && cnt <= 4'h7) begin
                        sdaOe <= !shift[6];
                        shift <= {shift[6:0], 1'b0};
                    end else if (cnt == 4'h8) begin
                        sdaOe <= 1'b0;
                    end else if (cnt == 4'h9 && mAck) begin
                        shift <= rdBuf; sdaOe <= !rdBuf[7];
                        ptr <= ptr + 8'h01; reqWe <= 1'b0;
                        reqAddr <= ptr + 8'h01; reqTgl <= ~reqTgl;
                    end else if (cnt == 4'h9) begin
                        state <= SL_IDLE;
                    end
                end
                default: state <= SL_IDLE;
            endcase
        end
    end

    a_quiet_unsel: assert property (
        @(posedge clk_link) disable iff (!rstLinkB)
        !selected |=> !sdaOe && state == SL_IDLE)
        else $error("data line driven while deselected");
    a_select_only: assert property (
        @(posedge clk_link) disable iff (!rstLinkB)
        $rose(state == SL_ADDR) |-> $past(selected))
        else $error("transfer began without select");
    cv_read_load: cover property (
        @(posedge clk_link) disable iff (!rstLinkB)
        $rose(state == SL_READ));
endmodule

// ---- tb/msc_host_model.sv ----
// Host controller model that drives the two-wire management bus
`timescale 1ns/1ps
module msc_host_model (
    input  wire logic clk_link, // Timing reference
    input  wire logic sdaWire,  // Resolved data line
    output logic      scl = 1'b1,    // Bus clock, high when idle
    output logic      sdaPull = 1'b0 // High pulls data low
);
    import msc_pkg::*;
    task automatic ph(input int n);
        repeat (n) @(posedge clk_link);
    endtask
    // Data moves only well after the clock falls, so it is never a start
    task automatic bitx(input logic b, output logic s);
        ph(5);
        sdaPull <= !b;
        ph(25);
        scl <= 1'b1;
        ph(25);
        s = sdaWire;
        scl <= 1'b0;
    endtask
    task automatic start();
        ph(5);
        sdaPull <= 1'b0;
        ph(5);
        scl <= 1'b1;
        ph(25);
        sdaPull <= 1'b1;
        ph(25);
        scl <= 1'b0;
    endtask
    task automatic stop();
        ph(5);
        sdaPull <= 1'b1;
        ph(25);
        scl <= 1'b1;
        ph(25);
        sdaPull <= 1'b0;
        ph(25);
    endtask
    // Sending all ones releases the line, so one task both writes and reads
    task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                        output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r[i]);
        end
        bitx(1'b1, nak);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] d,
                      output logic nak);
        logic [7:0] r;
        logic       n0, n1, n2;
        start();
        xfer({DEV_ADDR, 1'b0}, r, n0);
        xfer(adr, r, n1);
        xfer(d, r, n2);
        stop();
        nak = n0 | n1 | n2;
    endtask
    task automatic rd(input logic [7:0] adr, output logic [7:0] d,
                      output logic nak);
        logic [7:0] r;
        logic       n0, n1, n2, n3;
        start();
        xfer({DEV_ADDR, 1'b0}, r, n0);
        xfer(adr, r, n1);
        start();
        xfer({DEV_ADDR, 1'b1}, r, n2);
        xfer(8'hFF, d, n3);
        stop();
        nak = n0 | n1 | n2;
    endtask
endmodule

// ---- tb/msc_sideband_tb.sv ----
// Self-checking bench for the module sideband control block
`timescale 1ns/1ps
module msc_sideband_tb;
    import msc_pkg::*;
    localparam int INIT = 20;
    localparam int FILT = 4;
    logic        clk_sys, clk_link, rst_b, moduleSelectN, moduleResetN;
    logic        lowPowerSelect, transmitDisable, scl, sdaPull, sdaOut;
    logic        sdaOe, modulePresentN, intOut, intOe, txOff, lpAct;
    logic        los, initPending, nak, sdaWire, intWire;
    logic        sawDrive = 1'b0;
    logic [63:0] mon, m;
    logic [7:0]  rdByte;
    logic [15:0] lfsr = 16'h004C;
    int          err_total = 0;
    int          compares = 0;
    assign sdaWire = !(sdaPull || (sdaOe && !sdaOut));
    assign intWire = !(intOe && !intOut);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #3;
        forever #6 clk_link = ~clk_link;
    end
    always @(posedge clk_link) begin
        if (moduleSelectN && sdaOe) begin
            sawDrive <= 1'b1;
        end
    end
    msc_sideband #(.INIT_CYC(INIT), .RST_FILT(FILT)) i_msc_sideband (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_link(clk_link),
        .moduleSelectN(moduleSelectN), .moduleResetN(moduleResetN),
        .lowPowerSelect(lowPowerSelect), .transmitDisable(transmitDisable),
        .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .diagnosticMonitor(mon), .modulePresentN(modulePresentN),
        .interruptNOut(intOut), .interruptNOe(intOe), .txOff(txOff),
        .lowPowerActive(lpAct), .receiveLossAlarm(los),
        .initPending(initPending));
    msc_host_model i_msc_host_model (
        .clk_link(clk_link), .sdaWire(sdaWire), .scl(scl),
        .sdaPull(sdaPull));
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [3:0] expLos(input logic [63:0] v);
        for (int i = 0; i < LANES; i++) begin
            expLos[i] = v[16*i +: 16] < LOS_THR_RST;
        end
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic rdChk(input logic [7:0] adr, input logic [7:0] exp);
        i_msc_host_model.rd(adr, rdByte, nak);
        chk({7'h0, nak, rdByte}, {8'h0, exp});
    endtask
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Status is ignored until the pending bit drops
    task automatic waitInit();
        for (int n = 0; n < INIT + 10 && initPending !== 1'b0; n++) begin
            cyc(1);
        end
        chk(initPending, 1'b0);
        if (initPending !== 1'b0) begin
            print_verdict();
        end
    endtask
    initial begin
        rst_b = 1'b0;
        moduleSelectN = 1'b1;
        moduleResetN = 1'b1;
        lowPowerSelect = 1'b0;
        transmitDisable = 1'b0;
        mon = 64'h0100_0200_0300_0400;
        cyc(2);
        chk({modulePresentN, initPending}, 2'b01);
        rst_b <= 1'b1;
        moduleSelectN <= 1'b0;
        waitInit();
        cyc(2);
        chk({modulePresentN, intWire}, 2'b00);
        rdChk(ADR_FLAGS, 8'h01);
        rdChk(ADR_STATUS, 8'h00);
        i_msc_host_model.wr(ADR_FLAGS, 8'h01, nak);
        cyc(4);
        chk({nak, intWire}, 2'b01);
        $display("test power_up done");
        for (int c = 3; c >= 0; c--) begin
            i_msc_host_model.wr(ADR_CONTROL, {7'h0, c[0]}, nak);
            lfsr = nxt(lfsr);
            @(posedge clk_sys);
            transmitDisable <= c[1];
            lowPowerSelect <= lfsr[0];
            cyc(20);
            chk({nak, txOff, lpAct}, {c[0] | c[1], lfsr[0]});
        end
        rdChk(ADR_STATUS, {5'h0, lfsr[0], 2'b00});
        $display("test controls done");
        for (int k = 0; k < LANES; k++) begin
            for (int i = 0; i < LANES; i++) begin
                lfsr = nxt(lfsr);
                m[16*i +: 16] = lfsr | 16'h0010;
            end
            m[16*k +: 16] = 16'h000F;
            m[16*((k + 1) % LANES) +: 16] = LOS_THR_RST;
            @(posedge clk_sys);
            mon <= m;
            cyc(4);
            chk(los, |expLos(m));
            rdChk(ADR_LANE_LOS, {4'h0, expLos(m)});
            rdChk(ADR_MON_BASE + 8'(2 * k), m[16*k+8 +: 8]);
            rdChk(ADR_MON_BASE + 8'(2 * k + 1), m[16*k +: 8]);
        end
        @(posedge clk_sys);
        mon <= {4{LOS_THR_RST}};
        cyc(4);
        chk({los, intWire}, 2'b00);
        rdChk(ADR_FLAGS, 8'h02);
        i_msc_host_model.wr(ADR_THR_LO, 8'h11, nak);
        cyc(4);
        chk({nak, los}, 2'b01);
        rdChk(ADR_THR_LO, 8'h11);
        $display("test monitors done");
        @(posedge clk_sys);
        moduleSelectN <= 1'b1;
        i_msc_host_model.wr(ADR_CONTROL, 8'h01, nak);
        cyc(20);
        chk({nak, sawDrive, txOff}, 3'b100);
        @(posedge clk_sys);
        moduleSelectN <= 1'b0;
        i_msc_host_model.wr(ADR_CONTROL, 8'h01, nak);
        chk(nak, 1'b0);
        $display("test select done");
        @(posedge clk_sys);
        moduleResetN <= 1'b0;
        cyc(FILT - 2);
        moduleResetN <= 1'b1;
        cyc(10);
        chk({initPending, txOff}, 2'b01);
        moduleResetN <= 1'b0;
        cyc(FILT + 6);
        chk({initPending, txOff}, 2'b10);
        moduleResetN <= 1'b1;
        waitInit();
        cyc(2);
        chk(intWire, 1'b0);
        rdChk(ADR_CONTROL, 8'h00);
        $display("test module_reset done");
        print_verdict();
    end
endmodule
